// File: logic/sws_supervisor.sv
// Sleep and wake controller with supervisor, watchdog and real-time counter
module sws_supervisor #(
	parameter int WDOG_TICK     = sws_pkg::WDOG_TICK_CYC,
	parameter int SLOW_TICK     = sws_pkg::SLOW_TICK_CYC,
	parameter int STEP          = sws_pkg::STEP_CYC
) (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [11:0] s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	input  wire logic        supplyGood,
	input  wire logic        extResetN,
	input  wire logic        wakePin,
	input  wire logic        usbStandbyReq,
	input  wire logic        usbWakeReq,
	output logic             chipReset,
	output logic             nodePowerOn,
	output logic             nodeClockEn,
	output logic             asleep,
	output logic [7:0]       sleepConfig
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0]           sgS;
		logic [1:0]           erS;
		logic [1:0]           pinS;
		logic [1:0]           usS;
		logic [1:0]           uwS;
		logic                 pinLast;
		sws_pkg::sws_state_t  st;
		logic [7:0]           stepCnt;
		logic                 wakePend;
		logic [63:0]          rtc;
		logic [63:0]          cmp;
		logic [31:0]          slowInc;
		logic [15:0]          slowDiv;
		logic [7:0]           wakeCfg;
		logic [7:0]           sleepCfg;
		logic [15:0]          wdogLoad;
		logic [15:0]          wdogCnt;
		logic [15:0]          wdogDiv;
		logic [2:0]           cause;
		logic                 chipRst;
		logic                 powerOn;
		logic                 clockOn;
		logic                 sleeping;
		logic                 awHave;
		logic [11:0]          awAddr;
		logic                 wHave;
		logic [31:0]          wData;
		logic [3:0]           wStrb;
		logic                 bValid;
		logic [1:0]           bResp;
		logic                 rValid;
		logic [31:0]          rData;
		logic [1:0]           rResp;
	} sws_reg_t;

	sws_reg_t r;
	sws_reg_t next_r;
	logic [31:0] mem [0:31];
	logic        memWe;
	logic [4:0]  memIdx;
	logic [31:0] memWd;

	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction : mergeBytes

	function automatic logic isMem(input logic [11:0] a);
		return (a >= sws_pkg::OFF_MEM_BASE) && (a <= sws_pkg::OFF_MEM_END);
	endfunction : isMem

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic pinNow;
		logic pinEdge;
		logic stim;
		logic wr;
		logic sleepReq;
		logic supplyLost;
		logic wdogFire;
		logic [11:0] wa;
		logic [11:0] ra;
		pinNow = 1'b0;
		pinEdge = 1'b0;
		stim = 1'b0;
		wr = 1'b0;
		sleepReq = 1'b0;
		supplyLost = 1'b0;
		wdogFire = 1'b0;
		wa = r.awAddr;
		ra = s_axi_araddr;
		next_r = r;
		memWe = 1'b0;
		memIdx = 5'(r.awAddr[6:2]);
		memWd = 32'h00000000;
		next_r.sgS = {r.sgS[0], supplyGood};
		next_r.erS = {r.erS[0], extResetN};
		next_r.pinS = {r.pinS[0], wakePin};
		next_r.usS = {r.usS[0], usbStandbyReq};
		next_r.uwS = {r.uwS[0], usbWakeReq};
		pinNow = r.pinS[1];
		next_r.pinLast = pinNow;
		// Polarity bit picks rising or falling edge
		pinEdge = r.wakeCfg[sws_pkg::WCFG_PIN_POL] ? (pinNow & ~r.pinLast)
			: (~pinNow & r.pinLast);
		stim = (r.wakeCfg[sws_pkg::WCFG_PIN_EN] & pinEdge)
			| (r.wakeCfg[sws_pkg::WCFG_TMR_EN] & (r.rtc >= r.cmp))
			| (r.wakeCfg[sws_pkg::WCFG_USB_EN] & r.uwS[1]);
		// AXI write channels, taken in either order
		if (!r.awHave && s_axi_awvalid) begin
			next_r.awHave = 1'b1;
			next_r.awAddr = s_axi_awaddr;
		end
		if (!r.wHave && s_axi_wvalid) begin
			next_r.wHave = 1'b1;
			next_r.wData = s_axi_wdata;
			next_r.wStrb = s_axi_wstrb;
		end
		if (r.bValid && s_axi_bready) begin
			next_r.bValid = 1'b0;
		end
		wr = r.awHave && r.wHave && !r.bValid;
		// Real-time counter
		if (r.st == sws_pkg::ST_ASLEEP && r.wakeCfg[sws_pkg::WCFG_SLOW_EN]) begin
			if (r.slowDiv >= 16'(SLOW_TICK - 1)) begin
				next_r.slowDiv = 16'h0000;
				next_r.rtc = r.rtc + {32'h00000000, r.slowInc};
			end else begin
				next_r.slowDiv = r.slowDiv + 16'h0001;
			end
		end else begin
			next_r.slowDiv = 16'h0000;
			next_r.rtc = r.rtc + 64'h0000000000000001;
		end
		// Watchdog counts in 1 ms steps only while awake
		if (r.st == sws_pkg::ST_AWAKE) begin
			if (r.wdogDiv >= 16'(WDOG_TICK - 1)) begin
				next_r.wdogDiv = 16'h0000;
				if (r.wdogCnt == 16'h0000) begin
					wdogFire = 1'b1;
				end else begin
					next_r.wdogCnt = r.wdogCnt - 16'h0001;
				end
			end else begin
				next_r.wdogDiv = r.wdogDiv + 16'h0001;
			end
		end
		if (wr) begin
			next_r.awHave = 1'b0;
			next_r.wHave = 1'b0;
			next_r.bValid = 1'b1;
			next_r.bResp = 2'b00;
			if (wa == sws_pkg::OFF_CONTROL) begin
				sleepReq = r.wData[sws_pkg::CTL_SLEEP_BIT] & r.wStrb[0];
			end else if (wa == sws_pkg::OFF_WAKE_CFG) begin
				next_r.wakeCfg = 8'(mergeBytes({24'h0, r.wakeCfg}, r.wData, r.wStrb));
			end else if (wa == sws_pkg::OFF_SLEEP_CFG) begin
				next_r.sleepCfg = 8'(mergeBytes({24'h0, r.sleepCfg}, r.wData, r.wStrb));
			end else if (wa == sws_pkg::OFF_CMP_LO) begin
				next_r.cmp[31:0] = mergeBytes(r.cmp[31:0], r.wData, r.wStrb);
			end else if (wa == sws_pkg::OFF_CMP_HI) begin
				next_r.cmp[63:32] = mergeBytes(r.cmp[63:32], r.wData, r.wStrb);
			end else if (wa == sws_pkg::OFF_SLOW_INC) begin
				next_r.slowInc = mergeBytes(r.slowInc, r.wData, r.wStrb);
			end else if (wa == sws_pkg::OFF_WDOG_CFG) begin
				next_r.wdogLoad = 16'(mergeBytes({16'h0, r.wdogLoad}, r.wData, r.wStrb));
			end else if (wa == sws_pkg::OFF_WDOG_KICK) begin
				next_r.wdogCnt = r.wdogLoad;
				next_r.wdogDiv = 16'h0000;
			end else if (wa == sws_pkg::OFF_CAUSE) begin
				next_r.cause = r.cause & ~r.wData[2:0];
			end else if (isMem(wa)) begin
				memWe = 1'b1;
				memWd = mergeBytes(mem[memIdx], r.wData, r.wStrb);
			end else if (wa == sws_pkg::OFF_STATUS || wa == sws_pkg::OFF_RTC_LO
				|| wa == sws_pkg::OFF_RTC_HI) begin
				next_r.bResp = 2'b00;
			end else begin
				next_r.bResp = 2'b10;
			end
		end
		// AXI read
		if (r.rValid && s_axi_rready) begin
			next_r.rValid = 1'b0;
		end
		if (s_axi_arvalid && !r.rValid) begin
			next_r.rValid = 1'b1;
			next_r.rResp = 2'b00;
			if (ra == sws_pkg::OFF_CONTROL) begin
				next_r.rData = 32'h00000000;
			end else if (ra == sws_pkg::OFF_STATUS) begin
				next_r.rData = {25'h0, r.wakePend, r.st};
			end else if (ra == sws_pkg::OFF_WAKE_CFG) begin
				next_r.rData = {24'h0, r.wakeCfg};
			end else if (ra == sws_pkg::OFF_SLEEP_CFG) begin
				next_r.rData = {24'h0, r.sleepCfg};
			end else if (ra == sws_pkg::OFF_CMP_LO) begin
				next_r.rData = r.cmp[31:0];
			end else if (ra == sws_pkg::OFF_CMP_HI) begin
				next_r.rData = r.cmp[63:32];
			end else if (ra == sws_pkg::OFF_RTC_LO) begin
				next_r.rData = r.rtc[31:0];
			end else if (ra == sws_pkg::OFF_RTC_HI) begin
				next_r.rData = r.rtc[63:32];
			end else if (ra == sws_pkg::OFF_SLOW_INC) begin
				next_r.rData = r.slowInc;
			end else if (ra == sws_pkg::OFF_WDOG_CFG) begin
				next_r.rData = {16'h0, r.wdogLoad};
			end else if (ra == sws_pkg::OFF_WDOG_KICK) begin
				next_r.rData = {16'h0, r.wdogCnt};
			end else if (ra == sws_pkg::OFF_CAUSE) begin
				next_r.rData = {29'h0, r.cause};
			end else if (isMem(ra)) begin
				next_r.rData = mem[ra[6:2]];
			end else begin
				next_r.rData = 32'h00000000;
				next_r.rResp = 2'b10;
			end
		end
		sleepReq = sleepReq | r.usS[1];
		// Power state sequence
		next_r.stepCnt = (r.stepCnt == 8'h00) ? 8'h00 : r.stepCnt - 8'h01;
		case (r.st)
			sws_pkg::ST_AWAKE: begin
				next_r.wakePend = 1'b0;
				// Requests outside this state are simply ignored
				if (sleepReq) begin
					next_r.st = sws_pkg::ST_GATE_CLK;
					next_r.stepCnt = 8'(STEP);
				end
			end
			sws_pkg::ST_GATE_CLK: begin
				next_r.wakePend = r.wakePend | stim;
				if (r.stepCnt == 8'h00) begin
					next_r.st = sws_pkg::ST_PWR_DOWN;
					next_r.stepCnt = 8'(STEP);
				end
			end
			sws_pkg::ST_PWR_DOWN: begin
				next_r.wakePend = r.wakePend | stim;
				if (r.stepCnt == 8'h00) begin
					next_r.st = sws_pkg::ST_ASLEEP;
				end
			end
			sws_pkg::ST_ASLEEP: begin
				if (stim || r.wakePend) begin
					next_r.wakePend = 1'b0;
					next_r.st = sws_pkg::ST_PWR_UP;
					next_r.stepCnt = 8'(STEP);
				end
			end
			sws_pkg::ST_PWR_UP: begin
				if (r.stepCnt == 8'h00) begin
					next_r.st = sws_pkg::ST_UNGATE_CLK;
					next_r.stepCnt = 8'(STEP);
				end
			end
			sws_pkg::ST_UNGATE_CLK: begin
				if (r.stepCnt == 8'h00) begin
					// Count resumes where it froze; a kick or a supervisor reset reloads it
					next_r.st = sws_pkg::ST_AWAKE;
				end
			end
			default: begin
				next_r.st = sws_pkg::ST_AWAKE;
			end
		endcase
		// Supervisor: supplies and external reset; open pin floats to released
		supplyLost = ~r.sgS[1];
		next_r.chipRst = supplyLost | ~r.erS[1] | wdogFire;
		if (supplyLost || wdogFire || !r.erS[1]) begin
			next_r.st = sws_pkg::ST_AWAKE;
			next_r.wakePend = 1'b0;
			next_r.wdogCnt = r.wdogLoad;
			next_r.wdogDiv = 16'h0000;
			// Set wins over a clear in the same cycle, other cleared bits stay cleared
			next_r.cause[sws_pkg::CAUSE_WDOG_BIT] = next_r.cause[0] | wdogFire;
			next_r.cause[sws_pkg::CAUSE_SUPPLY_BIT] = next_r.cause[1] | supplyLost;
			next_r.cause[sws_pkg::CAUSE_EXT_BIT] = next_r.cause[2] | ~r.erS[1];
		end
		// Outputs are registered copies of the state decode
		next_r.powerOn = ~(next_r.st == sws_pkg::ST_PWR_DOWN || next_r.st == sws_pkg::ST_ASLEEP
			|| next_r.st == sws_pkg::ST_PWR_UP);
		next_r.clockOn = (next_r.st == sws_pkg::ST_AWAKE);
		next_r.sleeping = (next_r.st == sws_pkg::ST_ASLEEP);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (reset) begin
			r <= '0;
			r.sgS <= 2'b00;
			r.erS <= 2'b11;
			r.st <= sws_pkg::ST_AWAKE;
			r.chipRst <= 1'b1;
			r.powerOn <= 1'b1;
			r.clockOn <= 1'b1;
			r.wakeCfg <= sws_pkg::WAKE_CFG_RESET;
			r.sleepCfg <= sws_pkg::SLEEP_CFG_RESET;
			r.slowInc <= sws_pkg::SLOW_INC_RESET;
			r.wdogLoad <= sws_pkg::WDOG_RESET;
			r.wdogCnt <= sws_pkg::WDOG_RESET;
		end else begin
			r <= next_r;
		end
	end

	// Retained memory has no reset so its contents survive sleep
	always_ff @(posedge clock) begin
		if (memWe) begin
			mem[memIdx] <= memWd;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign s_axi_awready = ~r.awHave;
	assign s_axi_wready  = ~r.wHave;
	assign s_axi_bvalid  = r.bValid;
	assign s_axi_bresp   = r.bResp;
	assign s_axi_arready = ~r.rValid;
	assign s_axi_rvalid  = r.rValid;
	assign s_axi_rdata   = r.rData;
	assign s_axi_rresp   = r.rResp;
	assign chipReset     = r.chipRst;
	assign nodePowerOn   = r.powerOn;
	assign nodeClockEn   = r.clockOn;
	assign asleep        = r.sleeping;
	assign sleepConfig   = r.sleepCfg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_sleep_entry;
		@(posedge clock) disable iff (reset)
		(r.st == sws_pkg::ST_AWAKE && r.usS[1] && r.sgS[1] && r.erS[1])
			|=> (r.st == sws_pkg::ST_GATE_CLK);
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep request not taken");

	property p_no_jump;
		@(posedge clock) disable iff (reset)
		(r.st == sws_pkg::ST_AWAKE) |=> (r.st != sws_pkg::ST_ASLEEP);
	endproperty
	a_no_jump: assert property (p_no_jump) else $error("direct jump to sleep");

	property p_wake_only_asleep;
		@(posedge clock) disable iff (reset)
		(r.st == sws_pkg::ST_GATE_CLK) |=> (r.st != sws_pkg::ST_PWR_UP);
	endproperty
	a_wake_only_asleep: assert property (p_wake_only_asleep) else $error("woke early");

	property p_pending_wake;
		@(posedge clock) disable iff (reset)
		(r.st == sws_pkg::ST_ASLEEP && r.wakePend && r.sgS[1] && r.erS[1])
			|=> (r.st == sws_pkg::ST_PWR_UP);
	endproperty
	a_pending_wake: assert property (p_pending_wake) else $error("pending wake lost");

	property p_supply_reset;
		@(posedge clock) disable iff (reset)
		(!r.sgS[1]) |=> (r.chipRst && r.st == sws_pkg::ST_AWAKE);
	endproperty
	a_supply_reset: assert property (p_supply_reset) else $error("no reset on supply loss");

	property p_wdog_frozen;
		@(posedge clock) disable iff (reset)
		(r.st != sws_pkg::ST_AWAKE && r.sgS[1] && !r.bValid && !r.awHave)
			|=> $stable(r.wdogCnt);
	endproperty
	a_wdog_frozen: assert property (p_wdog_frozen) else $error("watchdog ran asleep");

	property p_rtc_fast;
		@(posedge clock) disable iff (reset)
		(r.st == sws_pkg::ST_AWAKE) |=> (r.rtc == $past(r.rtc) + 64'h0000000000000001);
	endproperty
	a_rtc_fast: assert property (p_rtc_fast) else $error("counter not ticking");

	property p_node_off;
		@(posedge clock) disable iff (reset)
		(r.st == sws_pkg::ST_ASLEEP) |-> (!nodePowerOn && !nodeClockEn);
	endproperty
	a_node_off: assert property (p_node_off) else $error("node powered asleep");
endmodule : sws_supervisor

// File: include/sws_pkg.sv
// Package of constants and types for the sleep and wake supervisor
// Behaviour
// - Sleep starts on a software control write or a USB standby request.
// - Wake starts on USB standby exit, the wake pin, or the timer compare.
// - Wake stimuli are acted on only in the deep-sleep state.
// - A stimulus seen while going to sleep is held and acted on once asleep.
// - Asleep, the wake pin wakes on its software-chosen edge polarity.
// - Asleep, the 64-bit real-time counter reaching the compare value wakes.
// - Asleep with USB enabled, a USB host wakeup wakes the device.
// - Asleep, the processing node and most peripherals are powered down.
// - Running, the real-time counter adds one per main oscillator tick.
// - If enabled, the counter moves to the slow oscillator when asleep.
// - On the slow oscillator, each tick adds a programmed increment.
// - Chip reset is held after power-up until all supplies are good.
// - Any supply loss resets the chip until recovery, then a cold start.
// - Works with the external reset pin left open, using power-on reset.
// - Watchdog is 16 bits, 1 ms steps, 1 ms to 65 s, separate from counter.
// - Watchdog expiry resets the device and records the cause readably.
// - Watchdog counts only while running and is frozen otherwise.
// - Supply loss during either transition issues a full system reset.
// - A 128-byte deep-sleep memory keeps its contents through deep sleep.
package sws_pkg;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [11:0] OFF_CONTROL    = 12'h000;
	localparam logic [11:0] OFF_STATUS     = 12'h004;
	localparam logic [11:0] OFF_WAKE_CFG   = 12'h008;
	localparam logic [11:0] OFF_SLEEP_CFG  = 12'h00c;
	localparam logic [11:0] OFF_CMP_LO     = 12'h010;
	localparam logic [11:0] OFF_CMP_HI     = 12'h014;
	localparam logic [11:0] OFF_RTC_LO     = 12'h018;
	localparam logic [11:0] OFF_RTC_HI     = 12'h01c;
	localparam logic [11:0] OFF_SLOW_INC   = 12'h020;
	localparam logic [11:0] OFF_WDOG_CFG   = 12'h024;
	localparam logic [11:0] OFF_WDOG_KICK  = 12'h028;
	localparam logic [11:0] OFF_CAUSE      = 12'h02c;
	localparam logic [11:0] OFF_MEM_BASE   = 12'h100;
	localparam logic [11:0] OFF_MEM_END    = 12'h17c;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTL_SLEEP_BIT   = 0;
	localparam int WCFG_PIN_EN     = 0;
	localparam int WCFG_PIN_POL    = 1;
	localparam int WCFG_TMR_EN     = 2;
	localparam int WCFG_USB_EN     = 3;
	localparam int WCFG_SLOW_EN    = 4;
	localparam int SCFG_WIDTH      = 8;
	localparam int CAUSE_WDOG_BIT  = 0;
	localparam int CAUSE_SUPPLY_BIT = 1;
	localparam int CAUSE_EXT_BIT   = 2;
	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [7:0]  WAKE_CFG_RESET  = 8'h00;
	localparam logic [7:0]  SLEEP_CFG_RESET = 8'h00;
	localparam logic [31:0] SLOW_INC_RESET  = 32'h00000001;
	localparam logic [15:0] WDOG_RESET      = 16'hffff;
	localparam int CLOCK_HZ      = 40000000;
	localparam int WDOG_TICK_US  = 1000;
	localparam int WDOG_TICK_CYC = CLOCK_HZ / 1000000 * WDOG_TICK_US;
	localparam int SLOW_OSC_HZ   = 31250;
	localparam int SLOW_TICK_CYC = CLOCK_HZ / SLOW_OSC_HZ;
	localparam int STEP_CYC      = 4;
	localparam int MEM_BYTES     = 128;
	// ------------------------------------------------------------
	// Power states
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_AWAKE      = 6'b000001,
		ST_GATE_CLK   = 6'b000010,
		ST_PWR_DOWN   = 6'b000100,
		ST_ASLEEP     = 6'b001000,
		ST_PWR_UP     = 6'b010000,
		ST_UNGATE_CLK = 6'b100000
	} sws_state_t;
endpackage : sws_pkg

// File: bench/sws_usb_model.sv
// USB-side requester model that raises standby and host-wake levels
module sws_usb_model #(
	parameter int WAKE_LEN = 4
) (
	input  wire logic clock,
	input  wire logic reset,
	input  wire logic nodeClockEn,
	input  wire logic standbyCmd,
	input  wire logic wakeCmd,
	output logic      usbStandbyReq,
	output logic      usbWakeReq
);
	// ------------------------------------------------------------
	// Request state
	// ------------------------------------------------------------
	logic pend;
	int   wakeCnt;
	always_ff @(posedge clock) begin
		if (reset) begin
			pend <= 1'b0;
			wakeCnt <= 0;
		end else begin
			if (standbyCmd)
				pend <= 1'b1;
			else if (!nodeClockEn)
				pend <= 1'b0;
			if (wakeCmd)
				wakeCnt <= WAKE_LEN;
			else if (wakeCnt > 0)
				wakeCnt <= wakeCnt - 1;
		end
	end
	// Standby is asked for only while the node clock runs, so never mid-transition
	assign usbStandbyReq = pend && nodeClockEn;
	// Short wake pulse, so a lost stimulus cannot hide behind a long level
	assign usbWakeReq = (wakeCnt > 0);
endmodule : sws_usb_model

// File: bench/sws_supervisor_test.sv
// Self-checking bench for the sleep and wake supervisor
module sws_supervisor_test;
	timeunit 1ns;
	timeprecision 100ps;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	localparam logic [11:0] UNMAPPED = 12'h030;
	logic        clock, reset, supplyGood, extResetN, wakePin, standbyCmd, wakeCmd, prevAsleep;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic        usbStandbyReq, usbWakeReq, chipReset, nodePowerOn, nodeClockEn, asleep;
	logic [7:0]  sleepConfig;
	int          errTotal, checks;

	sws_supervisor #(.WDOG_TICK(10), .SLOW_TICK(8), .STEP(4)) sws_supervisor_inst (
		.clock, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
		.s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
		.s_axi_rready, .s_axi_rdata, .s_axi_rresp, .supplyGood, .extResetN, .wakePin,
		.usbStandbyReq, .usbWakeReq, .chipReset, .nodePowerOn, .nodeClockEn, .asleep,
		.sleepConfig);
	sws_usb_model sws_usb_model_inst (.clock, .reset, .nodeClockEn, .standbyCmd, .wakeCmd,
		.usbStandbyReq, .usbWakeReq);

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errTotal++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic final_report();
		if (errTotal == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report
	task automatic axw(input logic [11:0] a, input logic [31:0] d);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge clock);
			if (!ad && s_axi_awready === 1'b1) begin
				ad = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wd && s_axi_wready === 1'b1) begin
				wd = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (s_axi_bvalid !== 1'b1)
			@(posedge clock);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axw
	task automatic axr(input logic [11:0] a);
		logic ad;
		ad = 1'b0;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (!ad && s_axi_arready === 1'b1) begin
				ad = 1'b1;
				s_axi_arvalid <= 1'b0;
			end
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axr
	task automatic waitSig(ref logic s, input logic v, input int lim, input string nm);
		int n;
		n = 0;
		while (s !== v && n < lim) begin
			@(posedge clock);
			n++;
		end
		chk(nm, {31'h0, s}, {31'h0, v});
	endtask : waitSig
	task automatic usbPulse(input logic standby);
		@(posedge clock);
		if (standby)
			standbyCmd <= 1'b1;
		else
			wakeCmd <= 1'b1;
		@(posedge clock);
		standbyCmd <= 1'b0;
		wakeCmd <= 1'b0;
	endtask : usbPulse
	task automatic sleepNow();
		axw(sws_pkg::OFF_CONTROL, 32'h1);
		waitSig(asleep, 1'b1, 100, "asleep");
		chk("nodePower", 32'(nodePowerOn), 32'h0);
		chk("nodeClock", 32'(nodeClockEn), 32'h0);
	endtask : sleepNow
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic tReset();
		logic [11:0] adr[5] = '{12'h004, 12'h008, 12'h00c, 12'h020, 12'h024};
		logic [31:0] exp[5] = '{32'h1, 32'h0, 32'h0, 32'h1, 32'hffff};
		repeat (20) @(posedge clock);
		chk("porHold", 32'(chipReset), 32'h1);
		supplyGood <= 1'b1;
		waitSig(chipReset, 1'b0, 20, "porRelease");
		foreach (adr[i]) begin
			axr(adr[i]);
			chk("resetValue", rd, exp[i]);
		end
		axw(UNMAPPED, 32'h1);
		chk("unmappedWrite", 32'(resp), 32'h2);
		axr(UNMAPPED);
		chk("unmappedRead", 32'(resp), 32'h2);
		axw(sws_pkg::OFF_SLEEP_CFG, 32'h5b);
		chk("sleepConfig", 32'(sleepConfig), 32'h5b);
	endtask : tReset
	task automatic tPin();
		axw(sws_pkg::OFF_MEM_BASE, 32'ha5a51234);
		axw(sws_pkg::OFF_MEM_END, 32'h0f0e0d0c);
		axw(sws_pkg::OFF_WAKE_CFG, 32'h3);
		wakePin <= 1'b1;
		repeat (8) @(posedge clock);
		wakePin <= 1'b0;
		repeat (8) @(posedge clock);
		sleepNow();
		repeat (40) @(posedge clock);
		chk("ignoredAwakeEdge", 32'(asleep), 32'h1);
		wakePin <= 1'b1;
		waitSig(nodeClockEn, 1'b1, 100, "risingWake");
		axr(sws_pkg::OFF_MEM_BASE);
		chk("memLow", rd, 32'ha5a51234);
		axr(sws_pkg::OFF_MEM_END);
		chk("memHigh", rd, 32'h0f0e0d0c);
		axw(sws_pkg::OFF_WAKE_CFG, 32'h1);
		sleepNow();
		wakePin <= 1'b0;
		waitSig(nodeClockEn, 1'b1, 100, "fallingWake");
	endtask : tPin
	task automatic tUsb();
		axw(sws_pkg::OFF_WAKE_CFG, 32'h8);
		usbPulse(1'b1);
		waitSig(asleep, 1'b1, 100, "usbSleep");
		usbPulse(1'b0);
		waitSig(nodeClockEn, 1'b1, 100, "usbWake");
		axw(sws_pkg::OFF_CONTROL, 32'h1);
		waitSig(nodeClockEn, 1'b0, 20, "gating");
		usbPulse(1'b0);
		waitSig(asleep, 1'b1, 100, "reachAsleep");
		waitSig(nodeClockEn, 1'b1, 100, "heldWake");
	endtask : tUsb
	task automatic tTimer();
		logic [31:0] target;
		axw(sws_pkg::OFF_WAKE_CFG, 32'h14);
		axw(sws_pkg::OFF_SLOW_INC, 32'h100);
		axr(sws_pkg::OFF_RTC_HI);
		axw(sws_pkg::OFF_CMP_HI, rd);
		axr(sws_pkg::OFF_RTC_LO);
		target = rd + 32'h2000;
		axw(sws_pkg::OFF_CMP_LO, target);
		sleepNow();
		// At one count per slow tick this would take far beyond the bound
		waitSig(nodeClockEn, 1'b1, 600, "timerWake");
		axr(sws_pkg::OFF_RTC_LO);
		chk("counterPast", {31'h0, rd >= target}, 32'h1);
	endtask : tTimer
	task automatic tWdog();
		axw(sws_pkg::OFF_WAKE_CFG, 32'h3);
		axw(sws_pkg::OFF_WDOG_CFG, 32'h3);
		axw(sws_pkg::OFF_WDOG_KICK, 32'h0);
		sleepNow();
		repeat (120) @(posedge clock);
		chk("wdogFrozen", 32'(chipReset), 32'h0);
		wakePin <= 1'b1;
		waitSig(nodeClockEn, 1'b1, 100, "wdogWake");
		waitSig(chipReset, 1'b1, 40, "wdogFire");
		waitSig(chipReset, 1'b0, 20, "wdogRelease");
		axw(sws_pkg::OFF_WDOG_CFG, 32'hffff);
		axw(sws_pkg::OFF_WDOG_KICK, 32'h0);
		axr(sws_pkg::OFF_CAUSE);
		chk("causeWdog", {31'h0, rd[0]}, 32'h1);
		// Clear every cause so the supply scenario must set its bit afresh
		axw(sws_pkg::OFF_CAUSE, 32'h7);
		axr(sws_pkg::OFF_CAUSE);
		chk("causeClear", {29'h0, rd[2:0]}, 32'h0);
	endtask : tWdog
	task automatic tSupply();
		axw(sws_pkg::OFF_CONTROL, 32'h1);
		waitSig(nodeClockEn, 1'b0, 20, "gating");
		supplyGood <= 1'b0;
		waitSig(chipReset, 1'b1, 10, "brownOut");
		repeat (20) @(posedge clock);
		chk("brownOutHold", 32'(chipReset), 32'h1);
		supplyGood <= 1'b1;
		waitSig(chipReset, 1'b0, 20, "recover");
		axr(sws_pkg::OFF_STATUS);
		chk("coldState", rd, 32'h1);
		axr(sws_pkg::OFF_CAUSE);
		chk("causeSupply", {31'h0, rd[1]}, 32'h1);
	endtask : tSupply
	// ------------------------------------------------------------
	// Sequence, jump monitor and watchdog
	// ------------------------------------------------------------
	always @(posedge clock) begin
		if (!reset && asleep !== prevAsleep && nodeClockEn !== 1'b0)
			chk("directJump", 32'h1, 32'h0);
		prevAsleep <= asleep;
	end
	initial begin
		{reset, extResetN} = 2'b11;
		{supplyGood, wakePin, standbyCmd, wakeCmd} = 4'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		errTotal = 0;
		checks = 0;
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		tReset();
		tPin();
		tUsb();
		tTimer();
		tWdog();
		tSupply();
		final_report();
	end
	initial begin
		repeat (40000) @(posedge clock);
		errTotal++;
		final_report();
	end
endmodule : sws_supervisor_test
